// *** irfb_consts.vh ***
// Purpose: constants of the interrupt request flag bank
// Assumes: included by bare name from the design files
// Notes:   byte addresses are 20-bit cpu data addresses
`ifndef IRFB_CONSTS_VH
`define IRFB_CONSTS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define IRFB_ADDR_W       20
`define IRFB_PEND_G2_LO   20'hfffd0
`define IRFB_PEND_G2_HI   20'hfffd1
`define IRFB_PEND_G0_LO   20'hfffe0
`define IRFB_PEND_G0_HI   20'hfffe1
`define IRFB_PEND_G1_LO   20'hfffe2
`define IRFB_PEND_G1_HI   20'hfffe3

// ----------------------------------------------------------------
// implemented bits of each halfword, others read zero
// ----------------------------------------------------------------
`define IRFB_IMPL_G0      16'hffff
`define IRFB_IMPL_G1      16'h05ff
`define IRFB_IMPL_G2      16'ha007
`define IRFB_RESET_VAL    16'h0000

// ----------------------------------------------------------------
// access sizes, group codes, timing
// ----------------------------------------------------------------
`define IRFB_SIZE_BIT     2'h0
`define IRFB_SIZE_BYTE    2'h1
`define IRFB_SIZE_HALF    2'h2
`define IRFB_GRP_0        2'h0
`define IRFB_GRP_1        2'h1
`define IRFB_GRP_2        2'h2
`define IRFB_GRP_NONE     2'h3
`define IRFB_WR_EXTRA     2'h2
`define IRFB_CNT_ZERO     2'h0
`define IRFB_CNT_ONE      2'h1

`endif

// *** irfb_flag_bank.v ***
// Purpose: six 8-bit interrupt request flag registers, three halfwords
// Assumes: peripheral requests are on clk; pin requests are asynchronous
// Notes:   read data and wait appear one cycle after the access
//
// Function
// - a source request or a software write of one sets its flag.
// - cpu acknowledge clears the acknowledged flag automatically.
// - a software write of zero clears a flag; reset clears all.
// - each byte register takes single-bit and full byte writes.
// - low and high byte pairs form three halfword registers.
// - all six registers read zero after reset.
// - each accepted bit, byte or even halfword write adds two instruction clocks.
// - group 0 low holds pins 5..0, low voltage, watchdog flags.
// - group 0 high holds serial0, dma and serial2 flags.
// - group 1 low holds timers 3..0, i2c-a, serial1 flags.
// - group 1 high bit 2 interval timer, bit 0 adc; rest zero.
// - group 2 low timers 7..5; high flash bit 7, md bit 5.
// - any of several sources sharing a bit sets that bit.
`include "irfb_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module irfb_flag_bank #(
  parameter PIN_COUNT = 6
) (
  // clock and reset
  input  wire                      clk,
  input  wire                      rst_n,
  // cpu data access
  input  wire                      cpu_wr,
  input  wire                      cpu_rd,
  input  wire [`IRFB_ADDR_W-1:0]   cpu_addr,
  input  wire [1:0]                cpu_size,
  input  wire [2:0]                cpu_bit,
  input  wire [15:0]               cpu_wdata,
  output reg  [15:0]               cpu_rdata_ff,
  output reg                       cpu_wait_ff,
  // cpu acknowledge
  input  wire                      ack_valid,
  input  wire [1:0]                ack_group,
  input  wire [3:0]                ack_bit,
  // external pin requests, asynchronous
  input  wire [PIN_COUNT-1:0]      pin_req,
  // group 0 sources
  input  wire                      low_voltage_req,
  input  wire                      watchdog_interval_req,
  input  wire                      serial0_rx_error_req,
  input  wire                      timer1_upper_req,
  input  wire                      serial0_rx_req,
  input  wire                      serial0_tx_req,
  input  wire                      sync_serial00_req,
  input  wire                      simple_i2c00_req,
  input  wire                      dma1_req,
  input  wire                      dma0_req,
  input  wire                      serial2_rx_error_req,
  input  wire                      serial2_rx_req,
  input  wire                      serial2_tx_req,
  input  wire                      sync_serial20_req,
  input  wire                      simple_i2c20_req,
  // group 1 sources
  input  wire [3:0]                timer_lo_req,
  input  wire                      i2c_a_req,
  input  wire                      serial1_rx_error_req,
  input  wire                      timer3_upper_req,
  input  wire                      serial1_rx_req,
  input  wire                      sync_serial11_req,
  input  wire                      simple_i2c11_req,
  input  wire                      serial1_tx_req,
  input  wire                      interval_timer_req,
  input  wire                      adc_done_req,
  // group 2 sources, timers 7..5
  input  wire [2:0]                timer_hi_req,
  input  wire                      flash_req,
  input  wire                      md_unit_req,
  // pending flags to the acknowledge logic
  output reg  [15:0]               pending_halfword_0_ff,
  output reg  [15:0]               pending_halfword_1_ff,
  output reg  [15:0]               pending_halfword_2_ff
);

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  // returns {group, high byte}; group none when unmapped
  function [2:0] addr_decode;
    input [`IRFB_ADDR_W-1:0] a;
    begin
      case (a)
        `IRFB_PEND_G0_LO: addr_decode = {`IRFB_GRP_0, 1'b0};
        `IRFB_PEND_G0_HI: addr_decode = {`IRFB_GRP_0, 1'b1};
        `IRFB_PEND_G1_LO: addr_decode = {`IRFB_GRP_1, 1'b0};
        `IRFB_PEND_G1_HI: addr_decode = {`IRFB_GRP_1, 1'b1};
        `IRFB_PEND_G2_LO: addr_decode = {`IRFB_GRP_2, 1'b0};
        `IRFB_PEND_G2_HI: addr_decode = {`IRFB_GRP_2, 1'b1};
        default:          addr_decode = {`IRFB_GRP_NONE, 1'b0};
      endcase
    end
  endfunction

  // write-enable mask and value for one halfword group
  function [31:0] wr_lanes;
    input [2:0]  dec;
    input [1:0]  grp;
    input [1:0]  size;
    input [2:0]  bitn;
    input [15:0] wd;
    reg   [15:0] en;
    reg   [15:0] val;
    begin
      en  = 16'h0000;
      val = 16'h0000;
      if (dec[2:1] == grp) begin
        case (size)
          `IRFB_SIZE_BIT: begin
            en  = 16'h0001 << {dec[0], bitn};
            val = {16{wd[0]}};
          end
          `IRFB_SIZE_BYTE: begin
            en  = dec[0] ? 16'hff00 : 16'h00ff;
            val = {wd[7:0], wd[7:0]};
          end
          `IRFB_SIZE_HALF: begin
            // halfword only at the even (low) address
            en  = dec[0] ? 16'h0000 : 16'hffff;
            val = wd;
          end
          default: begin
            en  = 16'h0000;
            val = 16'h0000;
          end
        endcase
      end
      wr_lanes = {en, val};
    end
  endfunction

  // one flag update: ack clear, then write, then requests win
  function [15:0] flag_next;
    input [15:0] cur;
    input [31:0] lanes;
    input [15:0] ack_clr;
    input [15:0] req;
    input [15:0] impl;
    begin
      flag_next = ((((cur & ~ack_clr) & ~lanes[31:16])
                   | (lanes[15:0] & lanes[31:16]))
                   | req) & impl;
    end
  endfunction

  // ----------------------------------------------------------------
  // request mapping
  // ----------------------------------------------------------------
  wire [PIN_COUNT-1:0] pin_sync;

  irfb_req_sync #(
    .WIDTH    (PIN_COUNT)
  ) u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   (pin_req),
    .pin_sync (pin_sync)
  );

  wire [15:0] req_g0;
  wire [15:0] req_g1;
  wire [15:0] req_g2;

  assign req_g0 = {serial0_rx_error_req | timer1_upper_req,
                   serial0_rx_req,
                   serial0_tx_req | sync_serial00_req
                     | simple_i2c00_req,
                   dma1_req, dma0_req,
                   serial2_rx_error_req, serial2_rx_req,
                   serial2_tx_req | sync_serial20_req
                     | simple_i2c20_req,
                   pin_sync[5:0],
                   low_voltage_req, watchdog_interval_req};
  assign req_g1 = {5'h00, interval_timer_req, 1'b0, adc_done_req,
                   timer_lo_req, i2c_a_req,
                   serial1_rx_error_req | timer3_upper_req,
                   serial1_rx_req | sync_serial11_req
                     | simple_i2c11_req,
                   serial1_tx_req};
  assign req_g2 = {flash_req, 1'b0, md_unit_req, 5'h00,
                   5'h00, timer_hi_req};

  // ----------------------------------------------------------------
  // software write and acknowledge decode
  // ----------------------------------------------------------------
  wire [2:0]  wr_dec;
  wire        wr_ok;
  wire [31:0] lanes_g0;
  wire [31:0] lanes_g1;
  wire [31:0] lanes_g2;
  wire [15:0] ack_mask;

  assign wr_dec = addr_decode(cpu_addr);
  // cpu is held while waiting, so a write seen then is not taken twice
  assign wr_ok  = cpu_wr & ~cpu_wait_ff;

  assign lanes_g0 = wr_ok ? wr_lanes(wr_dec, `IRFB_GRP_0, cpu_size,
                                     cpu_bit, cpu_wdata) : 32'h0;
  assign lanes_g1 = wr_ok ? wr_lanes(wr_dec, `IRFB_GRP_1, cpu_size,
                                     cpu_bit, cpu_wdata) : 32'h0;
  assign lanes_g2 = wr_ok ? wr_lanes(wr_dec, `IRFB_GRP_2, cpu_size,
                                     cpu_bit, cpu_wdata) : 32'h0;

  assign ack_mask = ack_valid ? (16'h0001 << ack_bit) : 16'h0000;

  // ----------------------------------------------------------------
  // flag registers
  // ----------------------------------------------------------------
  wire [15:0] nxt_pending_0;
  wire [15:0] nxt_pending_1;
  wire [15:0] nxt_pending_2;

  // set from requests wins over write-zero and ack clear
  assign nxt_pending_0 = flag_next(pending_halfword_0_ff, lanes_g0,
    (ack_group == `IRFB_GRP_0) ? ack_mask : 16'h0000, req_g0,
    `IRFB_IMPL_G0);
  assign nxt_pending_1 = flag_next(pending_halfword_1_ff, lanes_g1,
    (ack_group == `IRFB_GRP_1) ? ack_mask : 16'h0000, req_g1,
    `IRFB_IMPL_G1);
  assign nxt_pending_2 = flag_next(pending_halfword_2_ff, lanes_g2,
    (ack_group == `IRFB_GRP_2) ? ack_mask : 16'h0000, req_g2,
    `IRFB_IMPL_G2);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_halfword_0_ff <= `IRFB_RESET_VAL;
      pending_halfword_1_ff <= `IRFB_RESET_VAL;
      pending_halfword_2_ff <= `IRFB_RESET_VAL;
    end else begin
      pending_halfword_0_ff <= nxt_pending_0;
      pending_halfword_1_ff <= nxt_pending_1;
      pending_halfword_2_ff <= nxt_pending_2;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  reg  [15:0] rd_half;
  wire [2:0]  rd_dec;
  reg  [15:0] nxt_rdata;

  assign rd_dec = addr_decode(cpu_addr);

  always @* begin
    case (rd_dec[2:1])
      `IRFB_GRP_0: rd_half = pending_halfword_0_ff;
      `IRFB_GRP_1: rd_half = pending_halfword_1_ff;
      `IRFB_GRP_2: rd_half = pending_halfword_2_ff;
      default:     rd_half = 16'h0000;
    endcase
    if (!cpu_rd) begin
      nxt_rdata = cpu_rdata_ff;
    end else if (cpu_size == `IRFB_SIZE_HALF) begin
      nxt_rdata = rd_dec[0] ? 16'h0000 : rd_half;
    end else if (rd_dec[0]) begin
      nxt_rdata = {8'h00, rd_half[15:8]};
    end else begin
      nxt_rdata = {8'h00, rd_half[7:0]};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata_ff <= 16'h0000;
    end else begin
      cpu_rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // write wait: two extra instruction clocks
  // ----------------------------------------------------------------
  reg  [1:0] wait_cnt_ff;
  wire [1:0] nxt_wait_cnt;
  wire       wr_hit;

  // refused sizes, odd halfwords and unmapped writes enable no lane
  assign wr_hit       = |{lanes_g0[31:16], lanes_g1[31:16],
                          lanes_g2[31:16]};
  assign nxt_wait_cnt = wr_hit ? `IRFB_WR_EXTRA :
                        (wait_cnt_ff != `IRFB_CNT_ZERO) ?
                        wait_cnt_ff - `IRFB_CNT_ONE : `IRFB_CNT_ZERO;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt_ff <= `IRFB_CNT_ZERO;
      cpu_wait_ff <= 1'b0;
    end else begin
      wait_cnt_ff <= nxt_wait_cnt;
      cpu_wait_ff <= (nxt_wait_cnt != `IRFB_CNT_ZERO);
    end
  end

endmodule

`default_nettype wire

// *** irfb_flag_bank_sva.sv ***
// Purpose: port-level checker of the interrupt request flag bank
// Assumes: bound to irfb_flag_bank, single clock domain
// Notes:   set wins over clear, so request checks ignore writes and acks
`timescale 1ns/100ps
`default_nettype none

module irfb_flag_bank_sva #(
  parameter PIN_COUNT = 6
) (
  input wire logic clk, rst_n, cpu_wr, cpu_rd, cpu_wait_ff, ack_valid,
  input wire logic [19:0] cpu_addr,
  input wire logic [1:0] cpu_size, ack_group,
  input wire logic [3:0] ack_bit,
  input wire logic [15:0] cpu_wdata, cpu_rdata_ff,
  input wire logic [15:0] pending_halfword_0_ff, pending_halfword_1_ff,
  input wire logic [15:0] pending_halfword_2_ff,
  input wire logic [PIN_COUNT-1:0] pin_req,
  input wire logic [2:0] timer_hi_req,
  input wire logic serial0_rx_error_req, timer1_upper_req, flash_req,
  input wire logic serial1_rx_req, sync_serial11_req, simple_i2c11_req
);
  // -----------------------------------------------------------------
  // accepted write decode
  // -----------------------------------------------------------------
  wire logic map_a = cpu_addr[19:8] == 12'hfff &&
                     (cpu_addr[7:1] == 7'h68 || cpu_addr[7:2] == 6'h38);
  wire logic wr_ok = cpu_wr && !cpu_wait_ff && map_a && cpu_size != 2'h3 &&
                     !(cpu_size == 2'h2 && cpu_addr[0]);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_WAIT_TWO: assert property (
    wr_ok |=> cpu_wait_ff [*2] ##1 !cpu_wait_ff)
    else $error("write wait not exactly two cycles");
  AST_REFUSED_NO_WAIT: assert property (
    cpu_wr && !cpu_wait_ff && !wr_ok |=> !cpu_wait_ff)
    else $error("refused write raised wait");
  AST_BYTE_SET: assert property (
    wr_ok && cpu_addr == 20'hfffe0 && cpu_size == 2'h1
    |=> &(pending_halfword_0_ff[7:0] | ~$past(cpu_wdata[7:0])))
    else $error("byte write of ones did not set flags");
  AST_ACK_CLEAR: assert property (
    ack_valid && ack_group == 2'h2 && ack_bit == 4'hf
    && !flash_req && !cpu_wr |=> !pending_halfword_2_ff[15])
    else $error("acknowledge did not clear flag");
  AST_FIXED_ZERO: assert property (
    (pending_halfword_1_ff & 16'hfa00) == 16'h0000 &&
    (pending_halfword_2_ff & 16'h5ff8) == 16'h0000)
    else $error("unimplemented flag bit set");
  AST_SHARED_BIT: assert property (
    serial0_rx_error_req || timer1_upper_req
    |=> pending_halfword_0_ff[15])
    else $error("shared source did not set bit 15");
  AST_REQ_OVER_CLEAR: assert property (
    serial1_rx_req || sync_serial11_req || simple_i2c11_req
    |=> pending_halfword_1_ff[1])
    else $error("request lost against clear");
  // a one-cycle pin pulse is enough: two sync stages, then the flag
  AST_PIN_SYNC: assert property (
    pin_req[PIN_COUNT-1] |-> ##3 pending_halfword_0_ff[PIN_COUNT+1])
    else $error("pin request not latched");
  AST_TIMER_HI: assert property (
    timer_hi_req[0] |=> pending_halfword_2_ff[0])
    else $error("timer 5 request not latched");
  AST_READ_HI: assert property (
    cpu_rd && cpu_addr == 20'hfffe3 && cpu_size == 2'h1
    |=> cpu_rdata_ff == {8'h00, $past(pending_halfword_1_ff[15:8])})
    else $error("byte read data wrong");
endmodule
`default_nettype wire

// *** irfb_req_sync.v ***
// Purpose: two-stage synchroniser for asynchronous request pins
// Assumes: pins are not related to clk
// Notes:   stage one is read by stage two only
`timescale 1ns/100ps
`default_nettype none

module irfb_req_sync #(
  parameter WIDTH = 6
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // pins and synchronised levels
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_sync
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign pin_sync = sync_ff;

endmodule

`default_nettype wire

// *** irfb_src_model.sv ***
// Purpose: peripheral request sources facing the flag bank
// Assumes: one source per bit of req_vec, index 0 is low voltage
// Notes:   sources are on clk, so a one-cycle pulse is a full request
`timescale 1ns/100ps
`default_nettype none

module irfb_src_model (
  // request vector from the bench
  input  wire logic [32:0] req_vec,
  // group 0 sources
  output logic low_voltage_req, watchdog_interval_req, serial0_rx_error_req,
  output logic timer1_upper_req, serial0_rx_req, serial0_tx_req,
  output logic sync_serial00_req, simple_i2c00_req, dma1_req, dma0_req,
  output logic serial2_rx_error_req, serial2_rx_req, serial2_tx_req,
  output logic sync_serial20_req, simple_i2c20_req,
  // group 1 and group 2 sources
  output logic [3:0] timer_lo_req,
  output logic i2c_a_req, serial1_rx_error_req, timer3_upper_req,
  output logic serial1_rx_req, sync_serial11_req, simple_i2c11_req,
  output logic serial1_tx_req, interval_timer_req, adc_done_req,
  output logic [2:0] timer_hi_req,
  output logic flash_req, md_unit_req
);
  // shared-bit sources are separate bits here, so each one is exercised
  assign {md_unit_req, flash_req, timer_hi_req, adc_done_req,
          interval_timer_req, serial1_tx_req, simple_i2c11_req,
          sync_serial11_req, serial1_rx_req, timer3_upper_req,
          serial1_rx_error_req, i2c_a_req, timer_lo_req, simple_i2c20_req,
          sync_serial20_req, serial2_tx_req, serial2_rx_req,
          serial2_rx_error_req, dma0_req, dma1_req, simple_i2c00_req,
          sync_serial00_req, serial0_tx_req, serial0_rx_req,
          timer1_upper_req, serial0_rx_error_req, watchdog_interval_req,
          low_voltage_req} = req_vec;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench of the interrupt request flag bank
// Assumes: 250 MHz clock, fixed seed 70
// Notes:   flags are cleared between source checks by acknowledge
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0;
  logic ack_valid = 1'b0;
  logic [19:0] cpu_addr = 20'h00000;
  logic [1:0] cpu_size = 2'h0, ack_group = 2'h0;
  logic [2:0] cpu_bit = 3'h0;
  logic [3:0] ack_bit = 4'h0;
  logic [15:0] cpu_wdata = 16'h0000, exp_v;
  logic [5:0] pin_req = 6'h00;
  logic [32:0] req_vec = 33'h0;
  wire [15:0] cpu_rdata_ff, pending_halfword_0_ff, pending_halfword_1_ff;
  wire [15:0] pending_halfword_2_ff;
  wire cpu_wait_ff, low_voltage_req, watchdog_interval_req, dma1_req;
  wire serial0_rx_error_req, timer1_upper_req, serial0_rx_req, dma0_req;
  wire serial0_tx_req, sync_serial00_req, simple_i2c00_req, i2c_a_req;
  wire serial2_rx_error_req, serial2_rx_req, serial2_tx_req, flash_req;
  wire sync_serial20_req, simple_i2c20_req, serial1_rx_error_req;
  wire timer3_upper_req, serial1_rx_req, sync_serial11_req, md_unit_req;
  wire simple_i2c11_req, serial1_tx_req, interval_timer_req, adc_done_req;
  wire [3:0] timer_lo_req;
  wire [2:0] timer_hi_req;
  integer fail_count = 0, checked = 0, seed = 70, cyc = 0, i;
  int g;
  // group*16+bit of each source in req_vec order
  int map [0:32] = '{1, 0, 15, 15, 14, 13, 13, 13, 12, 11, 10, 9, 8, 8, 8,
    20, 21, 22, 23, 19, 18, 18, 17, 17, 17, 16, 26, 24, 32, 33, 34, 47, 45};
  logic [19:0] adr [0:5] = '{20'hfffe0, 20'hfffe1, 20'hfffe2, 20'hfffe3,
                             20'hfffd0, 20'hfffd1};
  logic [7:0] msk [0:5] = '{8'hff, 8'hff, 8'hff, 8'h05, 8'h07, 8'ha0};

  always #2 clk = ~clk;
  irfb_src_model irfb_src_model_i (.*);
  irfb_flag_bank irfb_flag_bank_i (.*);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] hw(input int grp);
    hw = grp == 0 ? pending_halfword_0_ff :
         grp == 1 ? pending_halfword_1_ff : pending_halfword_2_ff;
  endfunction
  task automatic wr(input logic [19:0] a, input logic [1:0] s,
                    input logic [2:0] b, input logic [15:0] d, input logic w);
    @(posedge clk);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_size <= s;
    cpu_bit <= b;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_wr <= 1'b0;
    #1 chk({15'h0, cpu_wait_ff}, {15'h0, w});
    @(posedge clk) #1 chk({15'h0, cpu_wait_ff}, {15'h0, w});
    @(posedge clk) #1 chk({15'h0, cpu_wait_ff}, 16'h0000);
  endtask
  task automatic rd(input logic [19:0] a, input logic [1:0] s,
                    input logic [15:0] e);
    @(posedge clk);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    cpu_size <= s;
    @(posedge clk);
    cpu_rd <= 1'b0;
    #1 chk(cpu_rdata_ff, e);
  endtask
  task automatic ack(input int gb);
    @(posedge clk);
    ack_valid <= 1'b1;
    ack_group <= gb[5:4];
    ack_bit <= gb[3:0];
    @(posedge clk);
    ack_valid <= 1'b0;
    #1 chk(hw(gb >> 4), 16'h0000);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // hang guard, the run needs well under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) rd(adr[i], 2'h1, 16'h0000);
    for (i = 0; i < 6; i++) begin
      wr(adr[i], 2'h1, 3'h0, 16'h00ff, 1'b1);
      rd(adr[i], 2'h1, {8'h00, msk[i]});
    end
    wr(20'hfffe0, 2'h0, 3'h3, 16'h0000, 1'b1);
    rd(20'hfffe0, 2'h2, 16'hfff7);
    wr(20'hfffe1, 2'h2, 3'h0, 16'h0000, 1'b0);
    wr(20'hfffe0, 2'h3, 3'h0, 16'h0000, 1'b0);
    wr(20'hfff00, 2'h1, 3'h0, 16'h0000, 1'b0);
    rd(20'hfffe0, 2'h2, 16'hfff7);
    // second write while wait is high must be dropped
    @(posedge clk);
    cpu_wr <= 1'b1;
    cpu_addr <= 20'hfffe2;
    cpu_size <= 2'h1;
    cpu_wdata <= 16'h0055;
    @(posedge clk);
    cpu_wdata <= 16'h00aa;
    @(posedge clk);
    cpu_wr <= 1'b0;
    rd(20'hfffe2, 2'h1, 16'h0055);
    for (i = 0; i < 6; i++) begin
      exp_v = 16'($random(seed));
      wr(adr[(i % 3) * 2], 2'h2, 3'h0, exp_v, 1'b1);
      rd(adr[(i % 3) * 2], 2'h2, exp_v & {msk[(i % 3) * 2 + 1],
         msk[(i % 3) * 2]});
    end
    for (i = 0; i < 3; i++) wr(adr[i * 2], 2'h2, 3'h0, 16'h0000, 1'b1);
    for (i = 0; i < 39; i++) begin
      g = i < 33 ? map[i] : i - 31;
      @(posedge clk);
      if (i < 33) req_vec <= 33'h1 << i;
      else pin_req <= 6'h01 << (i - 33);
      @(posedge clk);
      req_vec <= 33'h0;
      pin_req <= 6'h00;
      repeat (3) @(posedge clk);
      #1 chk(hw(g >> 4), 16'h0001 << g[3:0]);
      ack(g);
    end
    // software clear and request of one flag in the same cycle
    @(posedge clk);
    req_vec <= 33'h1 << 23;
    cpu_wr <= 1'b1;
    cpu_addr <= 20'hfffe2;
    cpu_size <= 2'h0;
    cpu_bit <= 3'h1;
    cpu_wdata <= 16'h0000;
    @(posedge clk);
    req_vec <= 33'h0;
    cpu_wr <= 1'b0;
    #1 chk(pending_halfword_1_ff, 16'h0002);
    repeat (2) @(posedge clk);
    ack(17);
    wr(20'hfffe0, 2'h1, 3'h0, 16'h00ff, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    #1 chk(pending_halfword_0_ff, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    complete_run();
  end
endmodule

bind irfb_flag_bank irfb_flag_bank_sva #(.PIN_COUNT(PIN_COUNT))
  irfb_flag_bank_sva_i (.*);
`default_nettype wire
